// *** src/gcpc_top.sv ***
/*
 * Global clock/control distribution and PLL control block with an
 * AHB-Lite register slave and one level interrupt.
 * Assumes every input is synchronous to hclk and that a single AHB
 * master issues whole-word single transfers.
 */
// Design decisions made here: the AHB-Lite slave port and the register offsets.
`default_nettype none
module gcpc_top
    import gcpc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [1:0] hresp,
    output logic [31:0] hrdata,
    output logic irq,
    input wire logic cfg_busy,
    input wire logic [5:0] pin_in,
    output logic [5:0] pin_out,
    output logic [5:0] pin_oe_n,
    input wire logic slow_oscillator,
    input wire logic fast_oscillator,
    output logic [7:0] global_net_driver,
    output logic global_io_float_ctl,
    output logic global_reset,
    output logic tile_clk,
    output logic tile_sr,
    output logic tile_ce,
    output logic [7:0] tile_lut,
    input wire logic pll_ref_clock,
    input wire logic outside_fb_input,
    input wire logic [7:0] fine_delay_ctl,
    input wire logic pll_freeze_lowpower,
    input wire logic cfg_serial_clk,
    input wire logic cfg_serial_data,
    output logic synth_clk_global_out,
    output logic synth_clk_fabric_out,
    output logic pll_lock
);
    // ==========================================================
    // Helpers
    function automatic logic route_ok(input logic [31:0] w);
        route_ok = !w[RT_SR_LO] && w[RT_CE_LO]
            && $countones(w[RT_LUT_LO +: NBUF]) <= LUT_MAX;
    endfunction

    function automatic logic div_ok(input logic [2:0] d);
        div_ok = d <= DIV_LOG_MAX;
    endfunction

    logic [CT_W-1:0] ctrl_r;
    logic [6:0] fbdiv_r;
    logic [2:0] div_log_r;
    logic [7:0] sdelay_r, delay_eff, delay_d_r;
    logic [2:0] clk_sel_r, sr_sel_r, ce_sel_r;
    logic [7:0] lut_mask_r;
    logic [5:0] io_mode_r, io_val_r;
    logic [EV_W-1:0] status_r, mask_r, ev;
    logic [11:0] addr_r;
    logic wr_pend_r, rd_pend_r, rd_clr;
    logic [15:0] ser_sh_r;
    logic [3:0] ser_cnt_r;
    logic sclk_d_r, ser_load, lock_d_r, relock, frz, ref_hold_r;
    logic synth_raw, lock_raw, clk_nxt;
    logic [7:0] net_nxt;

    // ==========================================================
    // AHB-Lite slave: writes zero-wait, reads one wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_r <= 12'h000;
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            hreadyout <= 1'b1;
        end else begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            hreadyout <= 1'b1;
            if (hsel && hready && htrans[1]) begin
                addr_r <= haddr[11:0];
                wr_pend_r <= hwrite;
                rd_pend_r <= !hwrite;
                hreadyout <= hwrite; // Read stalls one cycle
            end
        end
    end

    // Response is always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            hresp <= HRESP_OKAY;
        else
            hresp <= HRESP_OKAY;
    end

    // Read data mux; unmapped addresses read zero
    assign rd_clr = rd_pend_r && addr_r == OFF_STATUS;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_pend_r) begin
            unique case (addr_r)
                OFF_CTRL: hrdata <= {26'h0, ctrl_r};
                OFF_PLLCFG: hrdata <= {8'h00, sdelay_r, 5'h00, div_log_r,
                    1'b0, fbdiv_r};
                OFF_ROUTE: hrdata <= {8'h00, lut_mask_r, 5'h00, ce_sel_r,
                    1'b0, sr_sel_r, 1'b0, clk_sel_r};
                OFF_PINS: hrdata <= {18'h0, io_val_r, 2'h0, io_mode_r};
                OFF_STATUS: hrdata <= {27'h0, status_r};
                OFF_MASK: hrdata <= {27'h0, mask_r};
                OFF_STATE: hrdata <= {7'h00, cfg_busy, 2'h0, pin_in,
                    global_net_driver, 7'h00, pll_lock};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // Control and routing registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= '0;
            mask_r <= '0;
            io_mode_r <= 6'h00;
            io_val_r <= 6'h00;
        end else if (wr_pend_r) begin
            unique case (addr_r)
                OFF_CTRL: ctrl_r <= hwdata[CT_W-1:0];
                OFF_MASK: mask_r <= hwdata[EV_W-1:0];
                OFF_PINS: begin
                    io_mode_r <= hwdata[NPIN-1:0];
                    io_val_r <= hwdata[PN_OUT_LO +: NPIN];
                end
                default: ;
            endcase
        end
    end

    // Illegal routing words are dropped whole
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_sel_r <= 3'h0;
            sr_sel_r <= 3'h0;
            ce_sel_r <= 3'h1;
            lut_mask_r <= 8'h00;
        end else if (wr_pend_r && addr_r == OFF_ROUTE && route_ok(hwdata)) begin
            clk_sel_r <= hwdata[RT_CLK_LO +: 3];
            sr_sel_r <= hwdata[RT_SR_LO +: 3];
            ce_sel_r <= hwdata[RT_CE_LO +: 3];
            lut_mask_r <= hwdata[RT_LUT_LO +: NBUF];
        end
    end

    // PLL settings: serial frame wins over a bus write in one cycle
    assign ser_load = cfg_serial_clk && !sclk_d_r && ser_cnt_r == SER_LAST;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fbdiv_r <= FBDIV_RST;
            div_log_r <= 3'h0;
            sdelay_r <= 8'h00;
        end else if (ser_load) begin
            // Last bit is still on the data pin, so fields sit one lower
            fbdiv_r <= ser_sh_r[13:7];
            if (div_ok(ser_sh_r[6:4]))
                div_log_r <= ser_sh_r[6:4];
        end else if (wr_pend_r && addr_r == OFF_PLLCFG) begin
            fbdiv_r <= hwdata[PC_FB_LO +: 7];
            if (div_ok(hwdata[PC_DIV_LO +: 3]))
                div_log_r <= hwdata[PC_DIV_LO +: 3];
            sdelay_r <= hwdata[PC_DLY_LO +: 8];
        end
    end

    // Serial shifter, MSB first, sampled on serial clock rise
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sclk_d_r <= 1'b0;
            ser_sh_r <= 16'h0000;
            ser_cnt_r <= 4'h0;
        end else begin
            sclk_d_r <= cfg_serial_clk;
            if (cfg_serial_clk && !sclk_d_r) begin
                ser_sh_r <= {ser_sh_r[14:0], cfg_serial_data};
                ser_cnt_r <= ser_cnt_r + 4'h1;
            end
        end
    end

    // ==========================================================
    // Events, sticky status (set beats read-clear) and interrupt
    assign ev[EV_LOCK_UP] = lock_raw && !lock_d_r;
    assign ev[EV_LOCK_DN] = !lock_raw && lock_d_r;
    assign ev[EV_ROUTE] = wr_pend_r && addr_r == OFF_ROUTE
        && !route_ok(hwdata);
    assign ev[EV_DIV] = wr_pend_r && addr_r == OFF_PLLCFG
        && !div_ok(hwdata[PC_DIV_LO +: 3]);
    assign ev[EV_SER] = ser_load;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_r <= '0;
            lock_d_r <= 1'b0;
            irq <= 1'b0;
        end else begin
            lock_d_r <= lock_raw;
            status_r <= (rd_clr ? '0 : status_r) | ev;
            irq <= |(((rd_clr ? '0 : status_r) | ev) & mask_r);
        end
    end

    // ==========================================================
    // Global nets: pins and oscillators, muted during configuration
    always_comb begin
        net_nxt = {pin_in[5:4], fast_oscillator, slow_oscillator,
            pin_in[3:0]};
        net_nxt[7:6] = net_nxt[7:6] & ~io_mode_r[5:4];
        net_nxt[3:0] = net_nxt[3:0] & ~io_mode_r[3:0];
        if (cfg_busy)
            net_nxt = 8'h00;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            global_net_driver <= 8'h00;
            global_io_float_ctl <= 1'b1;
            global_reset <= 1'b1;
            pin_out <= 6'h00;
            pin_oe_n <= 6'h3f;
        end else begin
            global_net_driver <= net_nxt;
            global_io_float_ctl <= cfg_busy;
            global_reset <= cfg_busy;
            pin_out <= io_val_r;
            pin_oe_n <= cfg_busy ? 6'h3f : ~io_mode_r;
        end
    end

    // Tile inputs; set/reset forced while configuring
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tile_clk <= 1'b0;
            tile_sr <= 1'b1;
            tile_ce <= 1'b0;
            tile_lut <= 8'h00;
        end else begin
            tile_clk <= net_nxt[clk_sel_r];
            tile_sr <= net_nxt[sr_sel_r] | cfg_busy;
            tile_ce <= net_nxt[ce_sel_r];
            tile_lut <= net_nxt & lut_mask_r;
        end
    end

    // ==========================================================
    // PLL control: delay source, relock on change, bypass and freeze
    assign delay_eff = ctrl_r[CT_DLY_DYN] ? fine_delay_ctl : sdelay_r;
    // A phase change or a serial settings load disturbs the loop, so lock is redone
    assign relock = delay_eff != delay_d_r || ser_load;
    assign frz = pll_freeze_lowpower && ctrl_r[CT_GATE_A]
        && ctrl_r[CT_GATE_B];
    assign clk_nxt = frz ? ref_hold_r
        : (ctrl_r[CT_BYPASS] ? pll_ref_clock : synth_raw);

    gcpc_synth u_synth (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(ctrl_r[CT_PLL_RUN] && !frz),
        .ref_lvl(pll_ref_clock),
        .fb_lvl(outside_fb_input),
        .fb_external(ctrl_r[CT_FB_EXT]),
        .fbdiv(fbdiv_r),
        .div_log(div_log_r),
        .phase(delay_eff),
        .relock(relock),
        .synth_clk(synth_raw),
        .lock(lock_raw)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            delay_d_r <= 8'h00;
            ref_hold_r <= 1'b0;
            synth_clk_global_out <= 1'b0;
            synth_clk_fabric_out <= 1'b0;
            pll_lock <= 1'b0;
        end else begin
            delay_d_r <= delay_eff;
            if (!frz)
                ref_hold_r <= pll_ref_clock;
            synth_clk_global_out <= clk_nxt;
            synth_clk_fabric_out <= clk_nxt;
            pll_lock <= lock_raw && ctrl_r[CT_PLL_RUN];
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_CFG_FLOAT: assert property (cfg_busy |=> global_io_float_ctl
        && pin_oe_n == 6'h3f) else $error("pins not floated in config");
    AST_CFG_RESET: assert property (cfg_busy |=> global_reset
        && tile_sr) else $error("reset not held in config");
    AST_PARITY: assert property (!sr_sel_r[0] && ce_sel_r[0])
        else $error("set/reset or enable parity broken");
    AST_LUT_MAX: assert property ($countones(lut_mask_r) <= 4)
        else $error("more than four nets on LUT inputs");
    AST_DIV_RANGE: assert property (div_log_r <= 3'h6)
        else $error("output divider out of range");
    AST_OSC_SRC: assert property (!cfg_busy |=>
        global_net_driver[5:4] == $past({fast_oscillator, slow_oscillator}))
        else $error("oscillator not on nets four and five");
    AST_PIN_IO: assert property (!cfg_busy && io_mode_r[0] |=>
        !pin_oe_n[0] && !global_net_driver[0])
        else $error("I/O pin still on its net");
    AST_BYPASS: assert property (ctrl_r[CT_BYPASS] && !frz |=>
        synth_clk_global_out == $past(pll_ref_clock))
        else $error("bypass does not pass reference");
    AST_SAME_OUT: assert property (
        synth_clk_fabric_out == synth_clk_global_out)
        else $error("fabric and global outputs differ");
    AST_FREEZE: assert property (frz ##1 frz |=>
        $stable(synth_clk_global_out)) else $error("frozen output moved");
    AST_LOCK_RST: assert property (!ctrl_r[CT_PLL_RUN] |=>
        !pll_lock) else $error("lock high in PLL reset");
    AST_RELOCK: assert property (relock |=> ##1 !pll_lock)
        else $error("lock kept across phase change");

    COV_LOCK: cover property (ev[EV_LOCK_UP]);
    COV_SERIAL: cover property (ser_load);
    COV_IRQ_CLR: cover property (irq ##[1:4] rd_clr);
endmodule
`default_nettype wire

// *** include/gcpc_pkg.sv ***
/*
 * Constants shared by the global clock / PLL control block: register
 * offsets, field positions, reset values and PLL model limits.
 * Assumes a 32-bit AHB-Lite bus and a single 125 MHz clock.
 */
`default_nettype none
package gcpc_pkg;
    // ==========================================================
    // Register map (byte offsets)
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_PLLCFG = 12'h004;
    localparam logic [11:0] OFF_ROUTE = 12'h008;
    localparam logic [11:0] OFF_PINS = 12'h00c;
    localparam logic [11:0] OFF_STATUS = 12'h010;
    localparam logic [11:0] OFF_MASK = 12'h014;
    localparam logic [11:0] OFF_STATE = 12'h018;
    // ==========================================================
    // Control register bits
    localparam int CT_PLL_RUN = 0;
    localparam int CT_BYPASS = 1;
    localparam int CT_FB_EXT = 2;
    localparam int CT_DLY_DYN = 3;
    localparam int CT_GATE_A = 4;
    localparam int CT_GATE_B = 5;
    localparam int CT_W = 6;
    // ==========================================================
    // PLL configuration fields
    localparam int PC_FB_LO = 0;
    localparam int PC_DIV_LO = 8;
    localparam int PC_DLY_LO = 16;
    localparam logic [6:0] FBDIV_RST = 7'h01;
    localparam logic [2:0] DIV_LOG_MAX = 3'h6;
    localparam int SER_BITS = 16;
    localparam logic [3:0] SER_LAST = 4'hf;
    localparam int LOCK_PERIODS = 8;
    // ==========================================================
    // Routing and pin fields
    localparam int RT_CLK_LO = 0;
    localparam int RT_SR_LO = 4;
    localparam int RT_CE_LO = 8;
    localparam int RT_LUT_LO = 16;
    localparam int LUT_MAX = 4;
    localparam int PN_OUT_LO = 8;
    localparam int NBUF = 8;
    localparam int NPIN = 6;
    // ==========================================================
    // Status / event bits and state register layout
    localparam int EV_LOCK_UP = 0;
    localparam int EV_LOCK_DN = 1;
    localparam int EV_ROUTE = 2;
    localparam int EV_DIV = 3;
    localparam int EV_SER = 4;
    localparam int EV_W = 5;
    localparam int ST_NET_LO = 8;
    localparam int ST_PIN_LO = 16;
    localparam int ST_CFG = 24;
    localparam logic [1:0] HRESP_OKAY = 2'h0;
endpackage
`default_nettype wire

// *** src/gcpc_synth.sv ***
/*
 * Behavioural frequency synthesiser with lock detector.
 * Assumes the reference and external feedback levels are synchronous
 * to hclk and that the reference period exceeds the feedback divider.
 */
`default_nettype none
module gcpc_synth
    import gcpc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    input wire logic ref_lvl,
    input wire logic fb_lvl,
    input wire logic fb_external,
    input wire logic [6:0] fbdiv,
    input wire logic [2:0] div_log,
    input wire logic [7:0] phase,
    input wire logic relock,
    output logic synth_clk,
    output logic lock
);
    logic ref_d_r, fb_d_r, tick, ref_rise, fb_rise, fb_src;
    logic [15:0] period_r, per_cnt_r, prev_per_r, acc_r, acc_sum;
    logic [7:0] fb_cnt_r, prev_fb_r;
    logic [5:0] div_cnt_r;
    logic [3:0] good_r;

    // ==========================================================
    // Edge detection and feedback source choice
    assign fb_src = fb_external ? fb_lvl : synth_clk;
    assign ref_rise = ref_lvl & ~ref_d_r;
    assign fb_rise = fb_src & ~fb_d_r;
    assign acc_sum = acc_r + {9'h000, fbdiv};
    assign tick = run && period_r != 16'h0000 && acc_sum >= period_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_d_r <= 1'b0;
            fb_d_r <= 1'b0;
        end else begin
            ref_d_r <= ref_lvl;
            fb_d_r <= fb_src;
        end
    end

    // Reference period measurement
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            per_cnt_r <= 16'h0000;
            period_r <= 16'h0000;
        end else if (ref_rise) begin
            per_cnt_r <= 16'h0001;
            period_r <= per_cnt_r;
        end else if (per_cnt_r != 16'hffff) begin
            per_cnt_r <= per_cnt_r + 16'h0001;
        end
    end

    // Accumulator gives fbdiv ticks per reference period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_r <= 16'h0000;
        end else if (relock || !run) begin
            acc_r <= {8'h00, phase}; // Phase preload shifts the edges
        end else if (tick) begin
            acc_r <= acc_sum - period_r;
        end else begin
            acc_r <= acc_sum;
        end
    end

    // Output divider, power-of-two only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt_r <= 6'h00;
            synth_clk <= 1'b0;
        end else if (!run) begin
            div_cnt_r <= 6'h00;
            synth_clk <= 1'b0;
        end else if (tick) begin
            if (div_cnt_r >= 6'((7'h01 << div_log) - 7'h01)) begin
                div_cnt_r <= 6'h00;
                synth_clk <= ~synth_clk;
            end else begin
                div_cnt_r <= div_cnt_r + 6'h01;
            end
        end
    end

    // Lock: stable period and feedback count over several periods
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fb_cnt_r <= 8'h00;
            prev_fb_r <= 8'h00;
            prev_per_r <= 16'h0000;
            good_r <= 4'h0;
            lock <= 1'b0;
        end else if (!run || relock) begin
            fb_cnt_r <= 8'h00;
            good_r <= 4'h0;
            lock <= 1'b0;
        end else if (ref_rise) begin
            fb_cnt_r <= 8'h00;
            prev_fb_r <= fb_cnt_r;
            prev_per_r <= per_cnt_r;
            if (per_cnt_r == prev_per_r && fb_cnt_r != 8'h00
                    && fb_cnt_r == prev_fb_r) begin
                if (good_r != 4'(LOCK_PERIODS))
                    good_r <= good_r + 4'h1;
                else
                    lock <= 1'b1;
            end else begin
                good_r <= 4'h0;
                lock <= 1'b0;
            end
        end else if (fb_rise && fb_cnt_r != 8'hff) begin
            fb_cnt_r <= fb_cnt_r + 8'h01;
        end
    end
endmodule
`default_nettype wire

// *** sim/gcpc_fabric_model.sv ***
/* Fabric-side partner: reference clock level and serial reprogram port.
 * Assumes hclk is the block's sampling clock. */
`default_nettype none
module gcpc_fabric_model (
    input wire logic hclk,
    output logic pll_ref_clock,
    output logic cfg_serial_clk,
    output logic cfg_serial_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_r = 4'h0;
    // ==========================================================
    // Reference level: period of 20 hclk, above any fbdiv used
    initial pll_ref_clock = 1'b0;
    always @(posedge hclk) begin
        cnt_r <= (cnt_r == 4'h9) ? 4'h0 : cnt_r + 4'h1;
        if (cnt_r == 4'h9) begin
            pll_ref_clock <= ~pll_ref_clock;
        end
    end
    // ==========================================================
    // Serial frame, MSB first; clock idles low between frames
    initial cfg_serial_clk = 1'b0;
    initial cfg_serial_data = 1'b0;
    task automatic send(input logic [15:0] f);
        for (int i = 15; i >= 0; i--) begin
            @(posedge hclk);
            cfg_serial_data <= f[i];
            repeat (2) @(posedge hclk);
            cfg_serial_clk <= 1'b1;
            repeat (2) @(posedge hclk);
            cfg_serial_clk <= 1'b0;
        end
        // Released data line shows the inverse, not a stale bit
        cfg_serial_data <= ~f[0];
    endtask
endmodule
`default_nettype wire

// *** sim/tb.sv ***
/* Self-checking bench for gcpc_top: AHB-Lite master tasks, one task
 * per scenario. Assumes hready is looped back from hreadyout. */
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
 fail_count++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb;
    import gcpc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0, hresp;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, irq, cfg_busy = 1'b1, global_io_float_ctl;
    logic slow_oscillator = 1'b1, fast_oscillator = 1'b1, global_reset;
    logic [5:0] pin_in = 6'h3f, pin_out, pin_oe_n;
    logic [7:0] global_net_driver, tile_lut, fine_delay_ctl = 8'h00;
    logic tile_clk, tile_sr, tile_ce, pll_ref_clock, outside_fb_input = 1'b0;
    logic pll_freeze_lowpower = 1'b0, cfg_serial_clk, cfg_serial_data;
    logic synth_clk_global_out, synth_clk_fabric_out, pll_lock, prev;
    wire logic hready;
    int fail_count = 0, comparisons = 0;
    logic [31:0] bad [3] = '{32'h000f_0310, 32'h000f_0220, 32'h001f_0320};
    assign hready = hreadyout;
    always #4 hclk = ~hclk;
    gcpc_top dut (.*);
    gcpc_fabric_model fabric (.*);
    // ==========================================================
    // Bus and timing helpers
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Ready and data sampled at negedge, valid for the next rising edge
    task automatic wt;
        logic ok = 1'b0;
        for (int n = 0; n < 40 && !ok; n++) begin
            @(negedge hclk);
            ok = hreadyout;
            rd = hrdata;
            @(posedge hclk);
        end
        if (!ok) begin
            fail_count++;
            conclude;
        end
    endtask
    task automatic xfer(input logic w, logic [11:0] a, logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wt;
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wt;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge hclk);
        @(negedge hclk);
    endtask
    task automatic wait_lock;
        for (int n = 0; n < 800 && pll_lock !== 1'b1; n++) settle(1);
        `CHK("lock", 1'b1, pll_lock)
        if (pll_lock !== 1'b1) conclude;
    endtask
    task automatic drive(input logic [5:0] p, logic s, logic f);
        @(posedge hclk);
        pin_in <= p;
        slow_oscillator <= s;
        fast_oscillator <= f;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_cfg;
        settle(2);
        `CHK("float", 1'b1, global_io_float_ctl)
        `CHK("greset", 1'b1, global_reset)
        `CHK("nets", 8'h00, global_net_driver)
        `CHK("lock", 1'b0, pll_lock)
        @(posedge hclk);
        cfg_busy <= 1'b0;
        settle(3);
        `CHK("float", 1'b0, global_io_float_ctl)
        `CHK("greset", 1'b0, global_reset)
        drive(6'h15, 1'b1, 1'b0);
        settle(2);
        `CHK("nets", 8'h55, global_net_driver)
        drive(6'h2a, 1'b0, 1'b1);
        settle(2);
        `CHK("nets", 8'haa, global_net_driver)
        $display("test cfg and mapping done");
    endtask
    task automatic t_pins;
        drive(6'h3f, 1'b1, 1'b1);
        xfer(1'b1, OFF_PINS, 32'h0000_0101);
        settle(2);
        `CHK("oe_n", 6'h3e, pin_oe_n)
        `CHK("pout", 6'h01, pin_out)
        `CHK("nets", 8'hfe, global_net_driver)
        xfer(1'b1, OFF_PINS, 32'h0);
        xfer(1'b0, 12'h020, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        $display("test pins done");
    endtask
    task automatic t_route;
        xfer(1'b1, OFF_MASK, 32'h0000_001c);
        xfer(1'b1, OFF_ROUTE, 32'h000f_0320);
        settle(2);
        `CHK("lut", 8'h0f, tile_lut)
        `CHK("clk", 1'b1, tile_clk)
        drive(6'h3b, 1'b1, 1'b1);
        settle(2);
        `CHK("sr", 1'b0, tile_sr)
        `CHK("ce", 1'b1, tile_ce)
        for (int i = 0; i < 3; i++) begin
            xfer(1'b1, OFF_ROUTE, bad[i]);
            settle(2);
            `CHK("irq", 1'b1, irq)
            xfer(1'b0, OFF_STATUS, 32'h0);
            `CHK("status", 32'h0000_0004, rd)
            settle(2);
            `CHK("irq", 1'b0, irq)
        end
        xfer(1'b0, OFF_ROUTE, 32'h0);
        `CHK("route", 32'h000f_0320, rd)
        $display("test route done");
    endtask
    task automatic t_pll;
        fabric.send(16'h0340);
        settle(2);
        xfer(1'b0, OFF_PLLCFG, 32'h0);
        `CHK("pllcfg", 32'h0000_0203, rd)
        xfer(1'b0, OFF_STATUS, 32'h0);
        `CHK("status", 32'h0000_0010, rd)
        xfer(1'b1, OFF_PLLCFG, 32'h0000_0705);
        xfer(1'b0, OFF_PLLCFG, 32'h0);
        `CHK("pllcfg", 32'h0000_0205, rd)
        xfer(1'b0, OFF_STATUS, 32'h0);
        `CHK("status", 32'h0000_0008, rd)
        `CHK("lock", 1'b0, pll_lock)
        xfer(1'b1, OFF_CTRL, 32'h0000_0003);
        settle(2);
        prev = pll_ref_clock;
        // Bypass output is the reference delayed by one cycle
        repeat (60) begin
            @(posedge hclk);
            @(negedge hclk);
            `CHK("bypass", prev, synth_clk_global_out)
            `CHK("fabric", synth_clk_global_out, synth_clk_fabric_out)
            prev = pll_ref_clock;
        end
        // Freeze with both gates holds the output while reference runs
        @(posedge hclk);
        pll_freeze_lowpower <= 1'b1;
        xfer(1'b1, OFF_CTRL, 32'h0000_0033);
        settle(1);
        prev = synth_clk_global_out;
        repeat (25) begin
            settle(1);
            `CHK("freeze", prev, synth_clk_global_out)
        end
        @(posedge hclk);
        pll_freeze_lowpower <= 1'b0;
        $display("test pll done");
    endtask
    task automatic t_lock;
        xfer(1'b1, OFF_PLLCFG, 32'h0000_0004);
        xfer(1'b1, OFF_CTRL, 32'h0000_0001);
        wait_lock;
        xfer(1'b0, OFF_STATUS, 32'h0);
        `CHK("status", 32'h0000_0001, rd)
        // Fine delay is ignored until dynamic mode is chosen
        @(posedge hclk);
        fine_delay_ctl <= 8'h10;
        settle(3);
        `CHK("lock", 1'b1, pll_lock)
        xfer(1'b1, OFF_CTRL, 32'h0000_0009);
        settle(3);
        `CHK("lock", 1'b0, pll_lock)
        xfer(1'b0, OFF_STATUS, 32'h0);
        `CHK("status", 32'h0000_0002, rd)
        wait_lock;
        xfer(1'b1, OFF_CTRL, 32'h0);
        settle(2);
        `CHK("lock", 1'b0, pll_lock)
        $display("test lock done");
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_cfg;
        t_pins;
        t_route;
        t_pll;
        t_lock;
        conclude;
    end
endmodule
`default_nettype wire
